// >>> hdl/opfetch_map.svh
// Constants for the operand fetch and branch hint block.
// Assumes inclusion by both design files; definitions only.
`ifndef OPFETCH_MAP_SVH
`define OPFETCH_MAP_SVH

// Operand class codes
`define OPC_REG        2'h0
`define OPC_LIT        2'h1
`define OPC_SFR        2'h2
`define OPC_DISP       2'h3
// Operand field widths and ranges
`define SEL_W          5
`define SFR_COUNT      5'h03
`define DISP_W         23
// Shift and bit-alter
`define BITPOS_W       5
`define CC_BIT_ONE     1
// Branch hint codes
`define HINT_NONE      2'h0
`define HINT_TRUE      2'h1
`define HINT_FALSE     2'h2
// Reset value of state
`define WORD_ZERO      32'h0000_0000
`define DISP_ZERO      23'h00_0000

`endif

// >>> hdl/opfetch_pkg.sv
// Types for the operand fetch and branch hint block.
// Assumes no surroundings; types only.
package opfetch_pkg;
   typedef enum logic [1:0] {
      st_idle,
      st_exec,
      st_wb
   } instr_state_t;
endpackage

// >>> hdl/operand_resolve.sv
// Resolves one operand field to a 32-bit value.
// Assumes register file and sfr snapshot come from the same clock domain.
`timescale 1ns/1ns
`include "opfetch_map.svh"
module operand_resolve (
   input  wire logic [1:0]          class_in,  // Operand class
   input  wire logic [4:0]          sel_in,    // Register, literal, sfr no.
   input  wire logic                local_in,  // Local bank select
   input  wire logic [31:0]         glob_in,   // Global register value
   input  wire logic [31:0]         locl_in,   // Local register value
   input  wire logic [31:0]         sfr_in,    // Snapshot sfr value
   input  wire logic [`DISP_W-1:0]  disp_in,   // Displacement field
   output logic      [31:0]         val_out,   // Resolved value
   output logic                     bad_out    // Unimplemented sfr
);
   wire logic [31:0] reg_val;
   wire logic [31:0] lit_val;
   wire logic [31:0] disp_val;
   assign reg_val  = local_in ? locl_in : glob_in;
   assign lit_val  = {27'h000_0000, sel_in};
   assign disp_val = {{(32-`DISP_W){disp_in[`DISP_W-1]}}, disp_in};
   assign val_out  = (class_in == `OPC_REG)  ? reg_val :
                     (class_in == `OPC_LIT)  ? lit_val :
                     (class_in == `OPC_SFR)  ? sfr_in  : disp_val;
   assign bad_out  = (class_in == `OPC_SFR) && (sel_in >= `SFR_COUNT);
endmodule

// >>> hdl/operand_fetch_and_branch_hint.sv
// Decode-stage operand access, bit-alter, shift and static branch hinting.
// Assumes register and sfr files sit outside; fetch stream obeys redirects.
`timescale 1ns/1ns
`include "opfetch_map.svh"
module operand_fetch_and_branch_hint (
   input  wire logic               clk_in,          // Core clock 125 MHz
   input  wire logic               rst_n_in,        // Sync reset, low
   // Instruction issue
   input  wire logic               issue_in,        // Start instruction
   input  wire logic [1:0]         op_in,           // 0 mov 1 alter 2 shl
   input  wire logic [1:0]         cls_a_in,        // Source A class
   input  wire logic [4:0]         sel_a_in,        // Source A select
   input  wire logic               loc_a_in,        // Source A local bank
   input  wire logic [1:0]         cls_b_in,        // Source B class
   input  wire logic [4:0]         sel_b_in,        // Source B select
   input  wire logic               loc_b_in,        // Source B local bank
   input  wire logic               dst_sfr_in,      // Destination is sfr
   input  wire logic [4:0]         dst_sel_in,      // Destination number
   input  wire logic [2:0]         cond_code_in,    // Condition code flags
   // Register file view
   input  wire logic [31:0]        glob_a_in,       // Global for A
   input  wire logic [31:0]        locl_a_in,       // Local for A
   input  wire logic [31:0]        glob_b_in,       // Global for B
   input  wire logic [31:0]        locl_b_in,       // Local for B
   input  wire logic [31:0]        sfr0_in,         // Live sfr 0
   input  wire logic [31:0]        sfr1_in,         // Live sfr 1
   input  wire logic [31:0]        sfr2_in,         // Live sfr 2
   // Branch
   input  wire logic               br_issue_in,     // Branch decoded
   input  wire logic               br_cmp_fmt_in,   // Compare-and-branch fmt
   input  wire logic [1:0]         br_hint_in,      // Hint suffix
   input  wire logic [`DISP_W-1:0] br_disp_in,      // Displacement
   input  wire logic [31:0]        br_ip_in,        // Branch address
   input  wire logic               br_resolve_in,   // Outcome known
   input  wire logic               br_taken_in,     // Condition true
   // Results
   output logic      [31:0]        result_out,      // Register result
   output logic                    result_vld_out,  // Register write pulse
   output logic      [31:0]        sfr_wdata_out,   // Sfr write data
   output logic      [1:0]         sfr_wsel_out,    // Sfr write number
   output logic                    sfr_we_out,      // Sfr write pulse
   output logic                    op_fault_out,    // Unimplemented sfr
   output logic      [31:0]        fetch_ip_out,    // Fetch redirect
   output logic                    fetch_vld_out,   // Redirect pulse
   output logic                    squash_out,      // Discard wrong path
   output logic                    spec_out         // Speculating
);
   // ****************************************
   // Instruction sequencing
   // ****************************************
   opfetch_pkg::instr_state_t state;
   opfetch_pkg::instr_state_t next_state;
   logic [31:0] snap_a;
   logic [31:0] snap_b;
   logic [1:0]  cls_a;
   logic [1:0]  cls_b;
   logic [4:0]  sel_a;
   logic [4:0]  sel_b;
   logic        loc_a;
   logic        loc_b;
   logic [1:0]  op;
   logic        dst_sfr;
   logic [4:0]  dst_sel;
   logic        cc1;
   logic [31:0] final_val;

   wire logic [31:0] live_sfr_a;
   wire logic [31:0] live_sfr_b;
   wire logic [31:0] val_a;
   wire logic [31:0] val_b;
   wire logic        bad_a;
   wire logic        bad_b;
   wire logic [31:0] bit_mask;
   wire logic [31:0] alter_val;
   wire logic [31:0] shl_val;
   wire logic [31:0] next_val;
   wire logic        fault_now;

   assign live_sfr_a = (sel_a_in == 5'h00) ? sfr0_in :
                       (sel_a_in == 5'h01) ? sfr1_in : sfr2_in;
   assign live_sfr_b = (sel_b_in == 5'h00) ? sfr0_in :
                       (sel_b_in == 5'h01) ? sfr1_in : sfr2_in;

   // Sfr operand values use snapshots taken at instruction start; register values are live
   operand_resolve u_res_a (
      .class_in (cls_a),
      .sel_in   (sel_a),
      .local_in (loc_a),
      .glob_in  (glob_a_in),
      .locl_in  (locl_a_in),
      .sfr_in   (snap_a),
      .disp_in  (`DISP_ZERO),
      .val_out  (val_a),
      .bad_out  (bad_a)
   );
   operand_resolve u_res_b (
      .class_in (cls_b),
      .sel_in   (sel_b),
      .local_in (loc_b),
      .glob_in  (glob_b_in),
      .locl_in  (locl_b_in),
      .sfr_in   (snap_b),
      .disp_in  (`DISP_ZERO),
      .val_out  (val_b),
      .bad_out  (bad_b)
   );

   assign bit_mask  = 32'h0000_0001 << val_b[`BITPOS_W-1:0];
   assign alter_val = cc1 ? (val_a | bit_mask)
                          : (val_a & ~bit_mask);
   assign shl_val   = val_a << val_b[`BITPOS_W-1:0];
   assign next_val  = (op == 2'h1) ? alter_val :
                      (op == 2'h2) ? shl_val : val_a;
   assign fault_now = bad_a || bad_b ||
                      (dst_sfr && (dst_sel >= `SFR_COUNT));

   always_comb begin
      next_state = state;
      unique case (state)
         opfetch_pkg::st_idle: begin
            if (issue_in) begin
               next_state = opfetch_pkg::st_exec;
            end
         end
         opfetch_pkg::st_exec: begin
            next_state = opfetch_pkg::st_wb;
         end
         opfetch_pkg::st_wb: begin
            next_state = opfetch_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state <= opfetch_pkg::st_idle;
      end else begin
         state <= next_state;
      end
   end

   // Capture decode fields and sfr values once
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         snap_a  <= `WORD_ZERO;
         snap_b  <= `WORD_ZERO;
         cls_a   <= `OPC_REG;
         cls_b   <= `OPC_REG;
         sel_a   <= 5'h00;
         sel_b   <= 5'h00;
         loc_a   <= 1'b0;
         loc_b   <= 1'b0;
         op      <= 2'h0;
         dst_sfr <= 1'b0;
         dst_sel <= 5'h00;
         cc1     <= 1'b0;
      end else if (state == opfetch_pkg::st_idle && issue_in) begin
         snap_a  <= live_sfr_a;
         snap_b  <= (sel_b_in == sel_a_in) ? live_sfr_a
                                           : live_sfr_b;
         cls_a   <= cls_a_in;
         cls_b   <= cls_b_in;
         sel_a   <= sel_a_in;
         sel_b   <= sel_b_in;
         loc_a   <= loc_a_in;
         loc_b   <= loc_b_in;
         op      <= op_in;
         dst_sfr <= dst_sfr_in;
         dst_sel <= dst_sel_in;
         cc1     <= cond_code_in[`CC_BIT_ONE];
      end
   end

   // Result held internally; sfr written once at end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         final_val      <= `WORD_ZERO;
         result_out     <= `WORD_ZERO;
         result_vld_out <= 1'b0;
         sfr_wdata_out  <= `WORD_ZERO;
         sfr_wsel_out   <= 2'h0;
         sfr_we_out     <= 1'b0;
         op_fault_out   <= 1'b0;
      end else begin
         result_vld_out <= 1'b0;
         sfr_we_out     <= 1'b0;
         op_fault_out   <= 1'b0;
         if (state == opfetch_pkg::st_exec) begin
            final_val    <= next_val;
            op_fault_out <= fault_now;
            if (!fault_now && !dst_sfr) begin
               result_out     <= next_val;
               result_vld_out <= 1'b1;
            end
         end
         if (state == opfetch_pkg::st_wb && dst_sfr && !fault_now &&
             dst_sel < `SFR_COUNT) begin
            sfr_wdata_out <= final_val;
            sfr_wsel_out  <= dst_sel[1:0];
            sfr_we_out    <= 1'b1;
         end
      end
   end

   // ****************************************
   // Static branch hint
   // ****************************************
   logic        spec;
   logic        pred_taken;
   logic [31:0] alt_ip;

   wire logic        hint_taken;
   wire logic [31:0] target_ip;
   wire logic [31:0] fall_ip;
   wire logic        mispredict;

   assign hint_taken = (br_hint_in == `HINT_TRUE) ||
                       (br_hint_in == `HINT_NONE && br_cmp_fmt_in &&
                        br_disp_in[`DISP_W-1]);
   assign target_ip  = br_ip_in + {{(32-`DISP_W){br_disp_in[`DISP_W-1]}},
                                    br_disp_in};
   assign fall_ip    = br_ip_in + 32'h0000_0004;
   assign mispredict = spec && br_resolve_in &&
                       (br_taken_in != pred_taken);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         spec          <= 1'b0;
         pred_taken    <= 1'b0;
         alt_ip        <= `WORD_ZERO;
         fetch_ip_out  <= `WORD_ZERO;
         fetch_vld_out <= 1'b0;
         squash_out    <= 1'b0;
         spec_out      <= 1'b0;
      end else begin
         fetch_vld_out <= 1'b0;
         squash_out    <= 1'b0;
         if (spec && br_resolve_in) begin
            spec     <= 1'b0;
            spec_out <= 1'b0;
            if (mispredict) begin
               squash_out    <= 1'b1;
               fetch_ip_out  <= alt_ip;
               fetch_vld_out <= 1'b1;
            end
         end else if (!spec && br_issue_in) begin
            spec          <= 1'b1;
            spec_out      <= 1'b1;
            pred_taken    <= hint_taken;
            fetch_ip_out  <= hint_taken ? target_ip : fall_ip;
            alt_ip        <= hint_taken ? fall_ip : target_ip;
            fetch_vld_out <= 1'b1;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_alter_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      state == opfetch_pkg::st_exec && op == 2'h1 && !cc1 && !fault_now
      && !dst_sfr |=> !result_out[$past(val_b[4:0])])
      else $error("bit-alter did not clear");
   a_alter_set: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      state == opfetch_pkg::st_exec && op == 2'h1 && cc1 && !fault_now
      && !dst_sfr |=> result_out[$past(val_b[4:0])])
      else $error("bit-alter did not set");
   a_shl_one_clk: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      issue_in && state == opfetch_pkg::st_idle && op_in == 2'h2
      && !dst_sfr_in && cls_a_in == `OPC_LIT && cls_b_in == `OPC_LIT
      |=> ##1 result_vld_out)
      else $error("shift not done in one clock");
   a_sfr_once: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      sfr_we_out |=> !sfr_we_out ##1 !sfr_we_out)
      else $error("sfr written twice");
   a_sfr_stable: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      state != opfetch_pkg::st_idle |=> $stable(snap_a))
      else $error("sfr snapshot changed");
   a_sfr_same: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      state != opfetch_pkg::st_idle && cls_a == `OPC_SFR
      && cls_b == `OPC_SFR && sel_a == sel_b |-> val_a == val_b)
      else $error("one sfr read twice");
   a_sfr_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      sfr_we_out |-> sfr_wsel_out != 2'h3)
      else $error("unimplemented sfr written");
   a_fault_no_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      op_fault_out |=> !sfr_we_out)
      else $error("faulting instruction wrote sfr");
   a_lit_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      state == opfetch_pkg::st_exec && cls_a == `OPC_LIT
      |-> val_a[31:5] == 27'h000_0000)
      else $error("literal out of range");
   a_hint_path: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      !spec && br_issue_in && br_hint_in == `HINT_TRUE
      |=> fetch_vld_out && fetch_ip_out == $past(target_ip))
      else $error("hinted path not fetched");
   a_wrong_undo: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      mispredict |=> squash_out && fetch_vld_out
      && fetch_ip_out == $past(alt_ip))
      else $error("wrong guess not undone");
   c_mispredict: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      mispredict);
   c_sfr_write: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      sfr_we_out);
   c_alter: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      state == opfetch_pkg::st_exec && op == 2'h1);
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the operand fetch and branch hint block.
// Assumes the design files under hdl/ and a 125 MHz core clock.
`timescale 1ns/1ns
`include "opfetch_map.svh"
module testbench;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic               clk_in, rst_n_in, issue_in;
   logic [1:0]         op_in, cls_a_in, cls_b_in, br_hint_in;
   logic [4:0]         sel_a_in, sel_b_in, dst_sel_in;
   logic               loc_a_in, loc_b_in, dst_sfr_in;
   logic [2:0]         cond_code_in;
   logic [31:0]        glob_a_in, locl_a_in, glob_b_in, locl_b_in;
   logic [31:0]        sfr0_in, sfr1_in, sfr2_in, br_ip_in;
   logic               br_issue_in, br_cmp_fmt_in, br_resolve_in;
   logic               br_taken_in;
   logic [`DISP_W-1:0] br_disp_in;
   logic [31:0]        result_out, sfr_wdata_out, fetch_ip_out;
   logic [1:0]         sfr_wsel_out;
   logic               result_vld_out, sfr_we_out, op_fault_out;
   logic               fetch_vld_out, squash_out, spec_out;
   int                 num_errors, checks_done;

   operand_fetch_and_branch_hint i_dut (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .issue_in(issue_in),
      .op_in(op_in), .cls_a_in(cls_a_in), .sel_a_in(sel_a_in),
      .loc_a_in(loc_a_in), .cls_b_in(cls_b_in), .sel_b_in(sel_b_in),
      .loc_b_in(loc_b_in), .dst_sfr_in(dst_sfr_in),
      .dst_sel_in(dst_sel_in), .cond_code_in(cond_code_in),
      .glob_a_in(glob_a_in), .locl_a_in(locl_a_in),
      .glob_b_in(glob_b_in), .locl_b_in(locl_b_in),
      .sfr0_in(sfr0_in), .sfr1_in(sfr1_in), .sfr2_in(sfr2_in),
      .br_issue_in(br_issue_in), .br_cmp_fmt_in(br_cmp_fmt_in),
      .br_hint_in(br_hint_in), .br_disp_in(br_disp_in),
      .br_ip_in(br_ip_in), .br_resolve_in(br_resolve_in),
      .br_taken_in(br_taken_in), .result_out(result_out),
      .result_vld_out(result_vld_out), .sfr_wdata_out(sfr_wdata_out),
      .sfr_wsel_out(sfr_wsel_out), .sfr_we_out(sfr_we_out),
      .op_fault_out(op_fault_out), .fetch_ip_out(fetch_ip_out),
      .fetch_vld_out(fetch_vld_out), .squash_out(squash_out),
      .spec_out(spec_out)
   );

   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task report_and_stop;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Waits out write-back, then issues one instruction.
   // Live sfrs change after the start edge.
   // Returns just after the edge where the result pulse stands.
   task automatic run_op(input logic [1:0] op, ca, input logic [4:0] sa,
                         input logic la, input logic [1:0] cb,
                         input logic [4:0] sb, input logic lb, ds,
                         input logic [4:0] dsel, input logic [2:0] cc);
      @(posedge clk_in);
      #1;
      op_in = op; cls_a_in = ca; sel_a_in = sa; loc_a_in = la;
      cls_b_in = cb; sel_b_in = sb; loc_b_in = lb;
      dst_sfr_in = ds; dst_sel_in = dsel; cond_code_in = cc;
      issue_in = 1'b1;
      @(posedge clk_in);
      #1;
      issue_in = 1'b0;
      sfr0_in = ~sfr0_in;
      sfr1_in = ~sfr1_in;
      sfr2_in = ~sfr2_in;
      @(posedge clk_in);
      #1;
   endtask

   task automatic chk_res(input logic [31:0] exp);
      chk("result_vld_out", 32'h0000_0001, {31'h0, result_vld_out});
      chk("op_fault_out", 32'h0000_0000, {31'h0, op_fault_out});
      chk("result_out", exp, result_out);
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_regs;
      glob_a_in = 32'h1234_5678;
      locl_a_in = 32'hCAFE_0001;
      run_op(2'h0, `OPC_REG, 5'h0F, 1'b0, `OPC_LIT, 5'h00, 1'b0, 1'b0,
             5'h00, 3'h0);
      chk_res(32'h1234_5678);
      run_op(2'h0, `OPC_REG, 5'h0F, 1'b1, `OPC_LIT, 5'h00, 1'b0, 1'b0,
             5'h00, 3'h0);
      chk_res(32'hCAFE_0001);
   endtask

   task automatic t_literal;
      run_op(2'h0, `OPC_LIT, 5'h1F, 1'b0, `OPC_LIT, 5'h00, 1'b0, 1'b0,
             5'h00, 3'h0);
      chk_res(32'h0000_001F);
   endtask

   task automatic t_shift;
      glob_a_in = 32'h8765_4321;
      run_op(2'h2, `OPC_REG, 5'h03, 1'b0, `OPC_LIT, 5'h04, 1'b0, 1'b0,
             5'h00, 3'h0);
      chk_res(32'h7654_3210);
      run_op(2'h2, `OPC_LIT, 5'h01, 1'b0, `OPC_LIT, 5'h1F, 1'b0, 1'b0,
             5'h00, 3'h0);
      chk_res(32'h8000_0000);
   endtask

   task automatic t_alter;
      locl_a_in = 32'hFFFF_FFFF;
      glob_a_in = 32'h0000_0000;
      glob_b_in = 32'h0000_0025;
      run_op(2'h1, `OPC_REG, 5'h02, 1'b1, `OPC_LIT, 5'h1F, 1'b0, 1'b0,
             5'h00, 3'h5);
      chk_res(32'h7FFF_FFFF);
      run_op(2'h1, `OPC_REG, 5'h02, 1'b0, `OPC_REG, 5'h04, 1'b0, 1'b0,
             5'h00, 3'h2);
      chk_res(32'h0000_0020);
   endtask

   task automatic t_sfr_src;
      sfr1_in = 32'h0000_0003;
      run_op(2'h1, `OPC_SFR, 5'h01, 1'b0, `OPC_SFR, 5'h01, 1'b0, 1'b0,
             5'h00, 3'h2);
      chk_res(32'h0000_000B);
   endtask

   task automatic t_sfr_dst;
      sfr2_in = 32'h5A5A_0F0F;
      run_op(2'h0, `OPC_SFR, 5'h02, 1'b0, `OPC_LIT, 5'h00, 1'b0, 1'b1,
             5'h00, 3'h0);
      @(posedge clk_in);
      #1;
      chk("sfr_we_out", 32'h0000_0001, {31'h0, sfr_we_out});
      chk("sfr_wsel_out", 32'h0000_0000, {30'h0, sfr_wsel_out});
      chk("sfr_wdata_out", 32'h5A5A_0F0F, sfr_wdata_out);
      @(posedge clk_in);
      #1;
      chk("sfr_we_out", 32'h0000_0000, {31'h0, sfr_we_out});
   endtask

   task automatic t_sfr_bad(input logic [4:0] num);
      run_op(2'h0, `OPC_SFR, num, 1'b0, `OPC_LIT, 5'h00, 1'b0, 1'b1,
             5'h01, 3'h0);
      chk("op_fault_out", 32'h0000_0001, {31'h0, op_fault_out});
      chk("result_vld_out", 32'h0000_0000, {31'h0, result_vld_out});
      @(posedge clk_in);
      #1;
      chk("sfr_we_out", 32'h0000_0000, {31'h0, sfr_we_out});
   endtask

   task automatic t_branch(input logic cmp, input logic [1:0] hint,
                           input logic [`DISP_W-1:0] disp,
                           input logic [31:0] ip, input logic taken);
      logic [31:0] tgt, seq;
      logic        pred;
      tgt = ip + {{9{disp[`DISP_W-1]}}, disp};
      seq = ip + 32'h0000_0004;
      pred = (hint == `HINT_TRUE) ||
             (hint == `HINT_NONE && cmp && disp[`DISP_W-1]);
      br_cmp_fmt_in = cmp; br_hint_in = hint; br_disp_in = disp;
      br_ip_in = ip; br_issue_in = 1'b1;
      @(posedge clk_in);
      #1;
      br_issue_in = 1'b0;
      chk("fetch_vld_out", 32'h0000_0001, {31'h0, fetch_vld_out});
      chk("spec_out", 32'h0000_0001, {31'h0, spec_out});
      chk("fetch_ip_out", pred ? tgt : seq, fetch_ip_out);
      br_taken_in = taken;
      br_resolve_in = 1'b1;
      @(posedge clk_in);
      #1;
      br_resolve_in = 1'b0;
      chk("spec_out", 32'h0000_0000, {31'h0, spec_out});
      chk("squash_out", {31'h0, pred != taken}, {31'h0, squash_out});
      chk("fetch_vld_out", {31'h0, pred != taken},
          {31'h0, fetch_vld_out});
      if (pred != taken)
         chk("fetch_ip_out", taken ? tgt : seq, fetch_ip_out);
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      num_errors = 0; checks_done = 0;
      rst_n_in = 1'b0; issue_in = 1'b0; op_in = 2'h0;
      cls_a_in = 2'h0; sel_a_in = 5'h00; loc_a_in = 1'b0;
      cls_b_in = 2'h0; sel_b_in = 5'h00; loc_b_in = 1'b0;
      dst_sfr_in = 1'b0; dst_sel_in = 5'h00; cond_code_in = 3'h0;
      glob_a_in = 32'h0000_0000; locl_a_in = 32'h0000_0000;
      glob_b_in = 32'h0000_0000; locl_b_in = 32'h0000_0000;
      sfr0_in = 32'h0000_0000; sfr1_in = 32'h0000_0000;
      sfr2_in = 32'h0000_0000; br_issue_in = 1'b0;
      br_cmp_fmt_in = 1'b0; br_hint_in = 2'h0;
      br_disp_in = `DISP_ZERO; br_ip_in = 32'h0000_0000;
      br_resolve_in = 1'b0; br_taken_in = 1'b0;
      repeat (5) @(posedge clk_in);
      #1;
      rst_n_in = 1'b1;
      t_regs;
      t_literal;
      t_shift;
      t_alter;
      t_sfr_src;
      t_sfr_dst;
      t_sfr_bad(5'h03);
      t_sfr_bad(5'h1F);
      t_branch(1'b0, `HINT_TRUE, 23'h40_0000, 32'h0100_0000, 1'b0);
      t_branch(1'b1, `HINT_FALSE, 23'h3F_FFFF, 32'h0200_0000, 1'b1);
      t_branch(1'b1, `HINT_NONE, 23'h7F_FFF0, 32'h0300_0000, 1'b1);
      t_branch(1'b0, `HINT_NONE, 23'h00_0010, 32'h0400_0000, 1'b0);
      report_and_stop;
   end

   // Cuts a hang short
   initial begin
      #200000;
      num_errors++;
      report_and_stop;
   end
endmodule
